// ---- common/tip_defines.svh ----
// offsets, field positions, reset values and timing of the timed i/o port tile
// assumes a 32-bit classic wishbone slave and sys_clk at 40 MHz
// Behaviour
// - all pins of one port drive together or sample together, never mixed
// - ports exist at widths 1, 4, 8, 16 and 32 on fixed pins
// - a port drives its pins or samples them, optionally waiting for a condition
// - each core access to a port completes within one cycle
// - open-collector ports pull low for zero and float for one, per port
// - data passes through a transfer register and a serdes stage
// - a 16-bit port counter can hold a transfer until a chosen count
// - the port counter is readable at any time
// - every transfer saves the counter as its timestamp
// - an enabled serial link cuts every port off the link pins 12 to 15; their pins outside the link still work
// - a narrower enabled port wins shared pins; unshared wider pins still work
// - a port always transfers at its full nominal width
// - six clock blocks; block 0 ticks every sys_clk cycle (40 MHz), others programmable
// - a clock block may take its clock from a one-bit port
// - that port clock may be divided before pacing ports
// - ports accept an incoming ready strobe and make an outgoing one
// - after reset every port is paced by clock block 0
// - pin conditions raise events to the scheduler, not interrupts
// - while reset is held every general-purpose pin has its pull-down on
`ifndef TIP_DEFINES_SVH
`define TIP_DEFINES_SVH
`define TIP_NPORT 6
`define TIP_NCB 6
`define TIP_NPIN 32
`define TIP_REG_CTRL 5'h00
`define TIP_REG_DATA 5'h04
`define TIP_REG_TIME 5'h08
`define TIP_REG_STAMP 5'h0c
`define TIP_REG_COND 5'h10
`define TIP_REG_STAT 5'h14
`define TIP_CB_BASE 12'h100
`define TIP_CB_MASK 12'hfe0
`define TIP_LINK_ADR 12'h180
`define TIP_LINK_PIN_LO 12
`define TIP_LINK_PIN_N 4
`define TIP_CTRL_W 10
`define TIP_CTRL_MASK 32'h0000_03ff
`define TIP_CB_W 18
`define TIP_CB_MASK_W 32'h0003_ffff
`define TIP_PORT_CTRL_RST 32'h0000_0000
`define TIP_CB_CTRL_RST 32'h0000_0000
`define TIP_PD_RST 32'hffff_ffff
`define TIP_REF_CLK_HZ 100000000
`define TIP_SYS_CLK_HZ 40000000
`define TIP_REF_DIV ((`TIP_SYS_CLK_HZ + `TIP_REF_CLK_HZ - 1) / `TIP_REF_CLK_HZ)
`endif

// ---- common/tip_pkg.sv ----
// shared types of the timed i/o port tile
// assumes nothing from its surroundings
package tip_pkg;
    typedef enum logic [1:0] {
        TIP_COND_NONE = 2'b00,
        TIP_COND_EQ   = 2'b01,
        TIP_COND_NE   = 2'b10
    } tip_cond_type;
    // laid out as the port control register, bit 0 last
    typedef struct packed {
        logic         rdy_out_en;
        logic         rdy_in_en;
        logic [2:0]   clk_sel;
        tip_cond_type cond;
        logic         oc;
        logic         dir_out;
        logic         en;
    } tip_port_cfg_type;
    typedef struct packed {
        logic        src_sel;
        logic        use_pin;
        logic [15:0] div;
    } tip_cb_cfg_type;
    typedef struct packed {
        logic        tx_push;
        logic        rx_pop;
        logic        time_set;
        logic [31:0] wdata;
    } tip_port_req_type;
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] tv;
        logic [15:0] stamp;
        logic [31:0] tx;
        logic [31:0] sh;
        logic [31:0] rx;
        logic        armed;
        logic        tx_full;
        logic        sh_full;
        logic        rx_full;
        logic        strobe;
        logic        ev;
    } tip_port_state_type;
    typedef struct packed {
        logic        pin_prev;
        logic [15:0] cnt;
        logic        tick;
    } tip_cb_state_type;
endpackage

// ---- tb/tip_chk.sv ----
// bus and pin timing checks of the port tile
// assumes bound to tip_port_tile, one clock domain
module tip_chk (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        wb_cyc,
    input wire logic        wb_stb,
    input wire logic        wb_we,
    input wire logic [11:0] wb_adr,
    input wire logic [3:0]  wb_sel,
    input wire logic [31:0] wb_wdat,
    input wire logic [31:0] wb_rdat,
    input wire logic        wb_ack,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pin_pulldown_en,
    input wire logic [5:0]  outgoing_strobe,
    input wire logic [5:0]  port_event
);
    logic take;
    logic link_r;
    logic link_nxt;
    assign take = wb_cyc && wb_stb && !wb_ack;
    always_comb begin
        link_nxt = link_r;
        if (take && wb_we && wb_adr == 12'h180 && wb_sel[0]) begin
            link_nxt = wb_wdat[0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            link_r <= 1'b0;
        end else begin
            link_r <= link_nxt;
        end
    end
    chk_ack_next: assert property (@(posedge sys_clk) disable iff (reset)
        take |=> wb_ack) else $error("ack missing");
    chk_ack_pulse: assert property (@(posedge sys_clk) disable iff (reset)
        wb_ack |=> !wb_ack) else $error("ack too long");
    chk_ack_cause: assert property (@(posedge sys_clk) disable iff (reset)
        !take |=> !wb_ack) else $error("ack without request");
    chk_unmap_zero: assert property (@(posedge sys_clk) disable iff (reset)
        take && !wb_we && wb_adr < 12'h0c0 && wb_adr[4:0] >= 5'h18 |=> wb_rdat == 32'h0)
        else $error("unmapped read not zero");
    chk_cb0_fixed: assert property (@(posedge sys_clk) disable iff (reset)
        take && !wb_we && wb_adr == 12'h100 |=> wb_rdat == 32'h0)
        else $error("clock block 0 changed");
    chk_pd_reset: assert property (@(posedge sys_clk)
        reset |=> pin_pulldown_en == 32'hffff_ffff) else $error("pull-down off in reset");
    chk_reset_quiet: assert property (@(posedge sys_clk)
        reset |=> pin_oe == 32'h0 && outgoing_strobe == 6'h0) else $error("drive in reset");
    chk_link_free: assert property (@(posedge sys_clk) disable iff (reset)
        link_r [*3] |-> pin_oe[15:12] == 4'h0) else $error("link pins driven");
    cover property (@(posedge sys_clk) take && wb_we);
    cover property (@(posedge sys_clk) take && !wb_we);
    cover property (@(posedge sys_clk) |port_event);
    cover property (@(posedge sys_clk) |outgoing_strobe);
endmodule // tip_chk

bind tip_port_tile tip_chk chk_u (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat), .wb_rdat(wb_rdat),
    .wb_ack(wb_ack), .pin_oe(pin_oe), .pin_pulldown_en(pin_pulldown_en),
    .outgoing_strobe(outgoing_strobe), .port_event(port_event)
);

// ---- tb/tip_pin_model.sv ----
// pads and the hardware hung on them
// assumes outputs from the tile and a drive set by the bench
module tip_pin_model (
    input  wire logic        sys_clk,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pin_pulldown_en,
    input  wire logic [31:0] ext_val,
    input  wire logic [31:0] ext_oe,
    output logic      [31:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] last_r = 32'h0;
    always_ff @(posedge sys_clk) begin
        last_r <= pin_in;
    end
    // released pads fall to pull-down
    // an unpulled floating pad wanders, so a stale value never passes
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                  | (~pin_oe & ~ext_oe & ~pin_pulldown_en & ~last_r);
endmodule // tip_pin_model

// ---- tb/tip_port_tile_tb.sv ----
// self-checking bench of the port tile over wishbone
// assumes the pad model on the pins and the checker bound in
module tip_port_tile_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk;
    logic        reset;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [11:0] wb_adr;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic [31:0] pin_in;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [31:0] pin_pd;
    logic [5:0]  ready_in;
    logic [5:0]  ostb;
    logic [5:0]  pev;
    logic [31:0] ext_val;
    logic [31:0] ext_oe;
    logic [31:0] rd;
    logic [31:0] t0;
    int          error_cnt;
    int          num_checks;
    tip_port_tile dut_u (.sys_clk(sys_clk), .reset(reset), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf),
        .wb_wdat(wb_wdat), .wb_rdat(wb_rdat), .wb_ack(wb_ack), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldown_en(pin_pd),
        .ready_in(ready_in), .outgoing_strobe(ostb), .port_event(pev));
    tip_pin_model pads_u (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pulldown_en(pin_pd), .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic cycle, entered just after a rising edge
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wdat <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        chk("ack", 1'b1, wb_ack);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_ev(input int i, input logic s);
        logic hit;
        hit = 1'b0;
        repeat (60) begin
            @(posedge sys_clk);
            if ((s ? ostb[i] : pev[i]) === 1'b1) hit = 1'b1;
            if (hit) break;
        end
        chk("flag", 1'b1, hit);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #600000;
        error_cnt++;
        close_out();
    end
    initial begin
        reset = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
        {ready_in, ext_val, ext_oe, error_cnt, num_checks} = '0;
        repeat (3) @(posedge sys_clk);
        chk("pulldown", 32'hffff_ffff, pin_pd);
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        for (int p = 0; p < 6; p++) begin
            wb(1'b0, 12'(p * 32), 32'h0);
            chk("ctrl", 32'h0, rd);
        end
        wb(1'b1, 12'h100, 32'h5);
        wb(1'b0, 12'h100, 32'h0);
        chk("cb0", 32'h0, rd);
        wb(1'b0, 12'h018, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("reset test done");
        wb(1'b1, 12'h060, 32'h3);
        wb(1'b1, 12'h064, 32'ha5);
        repeat (5) @(posedge sys_clk);
        chk("out8", 32'h00ff_00a5, {8'h0, pin_oe[7:0], 8'h0, pin_out[7:0]});
        wb(1'b0, 12'h068, 32'h0);
        t0 = rd;
        wb(1'b0, 12'h068, 32'h0);
        chk("time", {16'h0, t0[15:0] + 16'h3}, rd & 32'hffff);
        $display("output test done");
        wb(1'b1, 12'h040, 32'h7);
        wb(1'b1, 12'h044, 32'h5);
        repeat (5) @(posedge sys_clk);
        chk("oc", 32'h0000_0fa0, {20'h0, pin_oe[7:0], pin_oe[3:0] & pin_out[3:0]});
        chk("wide", 32'h0000_00a0, {24'h0, pin_out[7:4], 4'h0});
        wb(1'b1, 12'h080, 32'h3);
        wb(1'b1, 12'h084, 32'hffff);
        repeat (5) @(posedge sys_clk);
        chk("p16", 32'h0000_00ff, {24'h0, pin_oe[15:8]});
        wb(1'b1, 12'h180, 32'h1);
        repeat (4) @(posedge sys_clk);
        chk("link", 32'h0000_000f, {24'h0, pin_oe[15:8]});
        wb(1'b1, 12'h180, 32'h0);
        for (int p = 2; p < 5; p++) wb(1'b1, 12'(p * 32), 32'h0);
        $display("sharing test done");
        ext_oe <= 32'hffff_ffff;
        wb(1'b1, 12'h0b0, 32'h1234_5678);
        wb(1'b1, 12'h0a0, 32'h9);
        repeat (10) @(posedge sys_clk);
        wb(1'b0, 12'h0b4, 32'h0);
        chk("nomatch", 32'h0, rd & 32'h1);
        ext_val <= 32'h1234_5678;
        wait_ev(5, 1'b0);
        wb(1'b0, 12'h0a4, 32'h0);
        chk("in32", 32'h1234_5678, rd);
        wb(1'b1, 12'h0a0, 32'h0);
        ext_val <= 32'h0002_0000;
        wb(1'b1, 12'h020, 32'h101);
        repeat (10) @(posedge sys_clk);
        wb(1'b0, 12'h034, 32'h0);
        chk("noready", 32'h0, rd & 32'h1);
        ready_in <= 6'h02;
        wait_ev(1, 1'b0);
        wb(1'b0, 12'h024, 32'h0);
        chk("in1", 32'h1, rd);
        wb(1'b1, 12'h020, 32'h0);
        $display("input test done");
        ext_oe <= 32'h0002_0000;
        wb(1'b1, 12'h000, 32'h203);
        wb(1'b1, 12'h004, 32'h1);
        wait_ev(0, 1'b1);
        repeat (2) @(posedge sys_clk);
        chk("strobe", 32'h3, {30'h0, pin_oe[16], pin_out[16]});
        wb(1'b0, 12'h008, 32'h0);
        t0 = rd + 32'h20;
        wb(1'b1, 12'h008, t0);
        wb(1'b1, 12'h004, 32'h0);
        repeat (40) @(posedge sys_clk);
        wb(1'b0, 12'h00c, 32'h0);
        chk("stamp", t0, rd);
        ext_val <= 32'h0;
        wb(1'b1, 12'h104, 32'h0003_0001);
        wb(1'b1, 12'h000, 32'h223);
        wb(1'b0, 12'h008, 32'h0);
        t0 = rd;
        repeat (8) begin
            ext_val[17] <= ~ext_val[17];
            repeat (4) @(posedge sys_clk);
        end
        wb(1'b0, 12'h008, 32'h0);
        chk("pinclk", t0 + 32'h2, rd);
        $display("strobe test done");
        close_out();
    end
endmodule // tip_port_tile_tb

// ---- verilog/tip_clock_block.sv ----
// one clock block: turns the reference or a one-bit port pin into a tick enable
// assumes src_pins already synchronised to sys_clk
module tip_clock_block (
    input  logic                    sys_clk,
    input  logic                    reset,
    input  tip_pkg::tip_cb_cfg_type cfg,
    input  logic [1:0]              src_pins,
    output logic                    tick
);
    tip_pkg::tip_cb_state_type st_r;
    tip_pkg::tip_cb_state_type st_nxt;
    logic                      src_ev;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.pin_prev = src_pins[cfg.src_sel];
        st_nxt.tick     = 1'b0;
        // rising pin edge as the clock source
        src_ev          = cfg.use_pin ? (st_nxt.pin_prev & ~st_r.pin_prev) : 1'b1;
        if (src_ev) begin
            if (st_r.cnt >= cfg.div) begin
                st_nxt.cnt  = 16'h0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule // tip_clock_block

// ---- verilog/tip_port.sv ----
// one timed port: transfer register, serdes stage, counter and timestamp
// assumes pin_in and ready_in synchronised and tick a one-cycle enable
module tip_port #(
    parameter int W = 8
) (
    input  logic                        sys_clk,
    input  logic                        reset,
    input  logic                        tick,
    input  tip_pkg::tip_port_cfg_type   cfg,
    input  logic [W-1:0]                cond_val,
    input  logic [W-1:0]                pin_in,
    input  logic                        ready_in,
    input  tip_pkg::tip_port_req_type   req,
    output logic [W-1:0]                pin_out,
    output logic [W-1:0]                pin_oe,
    output tip_pkg::tip_port_state_type stat
);
    tip_pkg::tip_port_state_type st_r;
    tip_pkg::tip_port_state_type st_nxt;
    logic                        go;
    logic                        cond_ok;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.ev = 1'b0;
        // one step per tick, wraps at 16 bits
        if (tick) st_nxt.cnt = st_r.cnt + 16'h1;
        // an armed time holds the transfer until the count matches
        go = tick & (~st_r.armed | (st_r.cnt == st_r.tv));
        case (cfg.cond)
            tip_pkg::TIP_COND_EQ: cond_ok = (pin_in == cond_val);
            tip_pkg::TIP_COND_NE: cond_ok = (pin_in != cond_val);
            default:              cond_ok = 1'b1;
        endcase
        if (!cfg.en) begin
            st_nxt.tx_full = 1'b0;
            st_nxt.sh_full = 1'b0;
            st_nxt.rx_full = 1'b0;
            st_nxt.strobe  = 1'b0;
        end else if (cfg.dir_out) begin
            if (tick) st_nxt.strobe = 1'b0;
            // transfer register moves into the serdes stage on the pins
            if (go && st_r.tx_full) begin
                st_nxt.sh      = st_r.tx;
                st_nxt.tx_full = 1'b0;
                st_nxt.armed   = 1'b0;
                st_nxt.stamp   = st_r.cnt;
                st_nxt.strobe  = cfg.rdy_out_en;
            end
            // a push into a full register is dropped; software checks status
            if (req.tx_push && !st_r.tx_full) begin
                st_nxt.tx      = 32'(req.wdata[W-1:0]);
                st_nxt.tx_full = 1'b1;
            end
        end else begin
            // sample once condition and ready strobe agree
            if (go && cond_ok && !st_r.sh_full && (!cfg.rdy_in_en || ready_in)) begin
                st_nxt.sh      = 32'(pin_in);
                st_nxt.sh_full = 1'b1;
                st_nxt.armed   = 1'b0;
                st_nxt.stamp   = st_r.cnt;
            end
            if (req.rx_pop) st_nxt.rx_full = 1'b0;
            if (st_r.sh_full && !st_r.rx_full) begin
                st_nxt.rx      = st_r.sh;
                st_nxt.rx_full = 1'b1;
                st_nxt.sh_full = 1'b0;
                st_nxt.ev      = 1'b1;
            end
        end
        if (req.time_set) begin
            st_nxt.tv    = req.wdata[15:0];
            st_nxt.armed = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stat    = st_r;
    assign pin_out = st_r.sh[W-1:0];
    // one enable for all pins; open collector floats the ones
    assign pin_oe  = (cfg.en && cfg.dir_out) ? (cfg.oc ? ~st_r.sh[W-1:0] : '1) : '0;
endmodule // tip_port

// ---- verilog/tip_port_tile.sv ----
// top of the timed i/o port tile: six ports, six clock blocks, pin sharing
// and a classic wishbone register slave
// assumes pad inputs asynchronous to sys_clk and a single-beat wishbone master
//
// The Wishbone register port and the address map were decided locally.
`include "tip_defines.svh"

module tip_port_tile (
    input  logic                  sys_clk,
    input  logic                  reset,
    input  logic                  wb_cyc,
    input  logic                  wb_stb,
    input  logic                  wb_we,
    input  logic [11:0]           wb_adr,
    input  logic [3:0]            wb_sel,
    input  logic [31:0]           wb_wdat,
    output logic [31:0]           wb_rdat,
    output logic                  wb_ack,
    input  logic [`TIP_NPIN-1:0]  pin_in,
    output logic [`TIP_NPIN-1:0]  pin_out,
    output logic [`TIP_NPIN-1:0]  pin_oe,
    output logic [`TIP_NPIN-1:0]  pin_pulldown_en,
    input  logic [`TIP_NPORT-1:0] ready_in,
    output logic [`TIP_NPORT-1:0] outgoing_strobe,
    output logic [`TIP_NPORT-1:0] port_event
);
    localparam int NP   = `TIP_NPORT;
    localparam int NC   = `TIP_NCB;
    localparam int NPIN = `TIP_NPIN;
    // widths narrowest first; index order is also pin precedence
    localparam int PW [NP] = '{1, 1, 4, 8, 16, 32};
    localparam int PB [NP] = '{16, 17, 0, 0, 0, 0};

    logic [NPIN-1:0] pin_s1_r;
    logic [NPIN-1:0] pin_s2_r;
    logic [NP-1:0]   rdy_s1_r;
    logic [NP-1:0]   rdy_s2_r;

    // register file
    logic [31:0] ctrl_r   [NP];
    logic [31:0] ctrl_nxt [NP];
    logic [31:0] cond_r   [NP];
    logic [31:0] cond_nxt [NP];
    logic [31:0] cb_r     [NC];
    logic [31:0] cb_nxt   [NC];
    logic        link_r;
    logic        link_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;

    // bus decode
    logic        acc;
    logic        port_hit;
    logic        cb_hit;
    logic        link_hit;
    logic [2:0]  idx;
    logic [2:0]  cidx;
    logic [4:0]  off;
    logic [31:0] wmask;

    // port and clock block wiring
    tip_pkg::tip_port_cfg_type   p_cfg  [NP];
    tip_pkg::tip_port_req_type   p_req  [NP];
    tip_pkg::tip_port_state_type p_st   [NP];
    logic [31:0]                 p_out  [NP];
    logic [31:0]                 p_oe   [NP];
    logic [NP-1:0]               p_tick;
    tip_pkg::tip_cb_cfg_type     cb_cfg [NC];
    logic [NC-1:0]               cb_tick;

    // pin side
    logic [NPIN-1:0] pout_r;
    logic [NPIN-1:0] pout_nxt;
    logic [NPIN-1:0] poe_r;
    logic [NPIN-1:0] poe_nxt;
    logic [NPIN-1:0] pd_r;
    logic [NPIN-1:0] pd_nxt;
    logic [NP-1:0]   strb_r;
    logic [NP-1:0]   strb_nxt;
    logic [NP-1:0]   ev_r;
    logic [NP-1:0]   ev_nxt;

    // pads are asynchronous, two stages before anything looks at them
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            rdy_s1_r <= '0;
            rdy_s2_r <= '0;
        end else begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
            rdy_s1_r <= ready_in;
            rdy_s2_r <= rdy_s1_r;
        end
    end

    always_comb begin
        acc      = wb_cyc & wb_stb & ~ack_r;
        idx      = wb_adr[7:5];
        off      = wb_adr[4:0];
        cidx     = wb_adr[4:2];
        port_hit = (wb_adr < `TIP_CB_BASE) && (int'(idx) < NP);
        cb_hit   = ((wb_adr & `TIP_CB_MASK) == `TIP_CB_BASE) && (int'(cidx) < NC);
        link_hit = (wb_adr == `TIP_LINK_ADR);
        wmask    = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        cond_nxt = cond_r;
        cb_nxt   = cb_r;
        link_nxt = link_r;
        rdat_nxt = '0;
        // every access answered the cycle after it is seen
        ack_nxt  = acc;
        for (int i = 0; i < NP; i++) begin
            p_req[i] = '{tx_push: 1'b0, rx_pop: 1'b0, time_set: 1'b0, wdata: wb_wdat};
        end
        if (acc && port_hit) begin
            case (off)
                `TIP_REG_CTRL: begin
                    rdat_nxt = ctrl_r[idx];
                    if (wb_we) begin
                        ctrl_nxt[idx] = ((ctrl_r[idx] & ~wmask) | (wb_wdat & wmask))
                                        & `TIP_CTRL_MASK;
                    end
                end
                `TIP_REG_DATA: begin
                    rdat_nxt           = p_st[idx].rx;
                    p_req[idx].tx_push = wb_we;
                    p_req[idx].rx_pop  = ~wb_we;
                end
                `TIP_REG_TIME: begin
                    // live count, whatever transfer is pending
                    rdat_nxt             = {16'h0, p_st[idx].cnt};
                    p_req[idx].time_set  = wb_we;
                end
                `TIP_REG_STAMP: begin
                    rdat_nxt = {16'h0, p_st[idx].stamp};
                end
                `TIP_REG_COND: begin
                    rdat_nxt = cond_r[idx];
                    if (wb_we) begin
                        cond_nxt[idx] = (cond_r[idx] & ~wmask) | (wb_wdat & wmask);
                    end
                end
                `TIP_REG_STAT: begin
                    rdat_nxt = {30'h0, p_st[idx].tx_full, p_st[idx].rx_full};
                end
                default: begin
                    rdat_nxt = '0;
                end
            endcase
        end else if (acc && cb_hit) begin
            rdat_nxt = cb_r[cidx];
            // block 0 stays on the reference, so it ignores writes
            if (wb_we && cidx != 3'h0) begin
                cb_nxt[cidx] = ((cb_r[cidx] & ~wmask) | (wb_wdat & wmask)) & `TIP_CB_MASK_W;
            end
        end else if (acc && link_hit) begin
            rdat_nxt = {31'h0, link_r};
            if (wb_we && wb_sel[0]) begin
                link_nxt = wb_wdat[0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            // clock select field resets to block 0
            for (int i = 0; i < NP; i++) begin
                ctrl_r[i] <= `TIP_PORT_CTRL_RST;
                cond_r[i] <= '0;
            end
            for (int k = 0; k < NC; k++) begin
                cb_r[k] <= `TIP_CB_CTRL_RST;
            end
            link_r <= 1'b0;
            ack_r  <= 1'b0;
            rdat_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cond_r <= cond_nxt;
            cb_r   <= cb_nxt;
            link_r <= link_nxt;
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    for (genvar k = 0; k < NC; k++) begin : g_cb
        // block 0 ticks every sys_clk cycle, the rest as programmed
        if (k == 0) begin : g_ref
            assign cb_cfg[k] = '{src_sel: 1'b0,
                                 use_pin: 1'b0,
                                 div:     16'(`TIP_REF_DIV - 1)};
        end else begin : g_prog
            assign cb_cfg[k] = tip_pkg::tip_cb_cfg_type'(cb_r[k][`TIP_CB_W-1:0]);
        end
        tip_clock_block u_cb (
            .sys_clk  (sys_clk),
            .reset    (reset),
            .cfg      (cb_cfg[k]),
            .src_pins ({pin_s2_r[PB[1]], pin_s2_r[PB[0]]}),
            .tick     (cb_tick[k])
        );
    end

    for (genvar i = 0; i < NP; i++) begin : g_port
        logic [PW[i]-1:0] outw;
        logic [PW[i]-1:0] oew;

        assign p_cfg[i]  = tip_pkg::tip_port_cfg_type'(ctrl_r[i][`TIP_CTRL_W-1:0]);
        // unused clock select codes leave the port unclocked
        assign p_tick[i] = (int'(p_cfg[i].clk_sel) < NC) ? cb_tick[p_cfg[i].clk_sel] : 1'b0;
        assign p_out[i]  = 32'(outw);
        assign p_oe[i]   = 32'(oew);

        tip_port #(
            .W (PW[i])
        ) u_port (
            .sys_clk  (sys_clk),
            .reset    (reset),
            .tick     (p_tick[i]),
            .cfg      (p_cfg[i]),
            .cond_val (cond_r[i][PW[i]-1:0]),
            // all own pins sampled, shared or not
            .pin_in   (pin_s2_r[PB[i] +: PW[i]]),
            .ready_in (rdy_s2_r[i]),
            .req      (p_req[i]),
            .pin_out  (outw),
            .pin_oe   (oew),
            .stat     (p_st[i])
        );
    end

    always_comb begin
        int  own;
        logic in_link;
        own      = NP;
        in_link  = 1'b0;
        pout_nxt = '0;
        poe_nxt  = '0;
        pd_nxt   = '0;
        for (int j = 0; j < NPIN; j++) begin
            own     = NP;
            in_link = link_r && (j >= `TIP_LINK_PIN_LO)
                      && (j < `TIP_LINK_PIN_LO + `TIP_LINK_PIN_N);
            // narrowest enabled port owns a shared pin
            for (int i = NP - 1; i >= 0; i--) begin
                if (p_cfg[i].en && (j >= PB[i]) && (j < PB[i] + PW[i])) begin
                    own = i;
                end
            end
            // link pins cut off every port mapped there
            if (in_link) begin
                own = NP;
            end
            if (own < NP) begin
                pout_nxt[j] = p_out[own][j - PB[own]];
                poe_nxt[j]  = p_oe[own][j - PB[own]];
                pd_nxt[j]   = ~p_cfg[own].dir_out;
            end else begin
                pd_nxt[j] = ~in_link;
            end
        end
        for (int i = 0; i < NP; i++) begin
            strb_nxt[i] = p_st[i].strobe;
            // fresh input data goes straight out as an event
            ev_nxt[i]   = p_st[i].ev;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pout_r <= '0;
            poe_r  <= '0;
            // pull-downs on while reset is held
            pd_r   <= `TIP_PD_RST;
            strb_r <= '0;
            ev_r   <= '0;
        end else begin
            pout_r <= pout_nxt;
            poe_r  <= poe_nxt;
            pd_r   <= pd_nxt;
            strb_r <= strb_nxt;
            ev_r   <= ev_nxt;
        end
    end

    assign wb_ack          = ack_r;
    assign wb_rdat         = rdat_r;
    assign pin_out         = pout_r;
    assign pin_oe          = poe_r;
    assign pin_pulldown_en = pd_r;
    assign outgoing_strobe = strb_r;
    assign port_event      = ev_r;
endmodule // tip_port_tile
